// *** rtl/pacfg_top.sv ***
// What this block does
// RQ1 - A proximity result above the high threshold raises the proximity flag once persistence is met.
// RQ2 - The interrupt pin asserts whenever a flag is set and its enable is high.
// RQ3 - Proximity persistence code 0 fires on every valid result, 1 on the first excursion of a run, 2-15 on that many in a row.
// RQ4 - Light persistence codes map to 0, 1, 2, 3 and then 5, 10 ... 60 consecutive excursions.
// RQ5 - Consecutive proximity excursions are counted and fire when the count equals the setting.
// RQ6 - A proximity result inside the window clears its run counter.
// RQ7 - Consecutive clear-channel excursions are counted and fire when the count equals the setting.
// RQ8 - A clear-channel result inside the window clears its run counter.
// RQ9 - The wait timer is a down counter lasting (setting plus one) ticks of 2.8 ms.
// RQ10 - The long-wait bit stretches the programmed wait twelvefold.
// RQ11 - Each train emits at most count plus one pulses, each 4, 8, 16 or 32 us wide.
// RQ12 - Software writes the reserved configuration bits with their default patterns.
// RQ13 - A proximity result below the low threshold raises the flag once persistence is met.
// RQ14 - Reserved configuration bits are stored but steer nothing.
`timescale 1ns/1ps
module pacfg_top #(
    parameter int TICK_CYCLES = pacfg_pkg::WAIT_TICK_CYCLES,
    parameter int LIGHT_DW    = 16
) (
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic [7:0]          REG_ADDR,
    input  wire logic [7:0]          REG_WDATA,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    output logic      [7:0]          REG_RDATA,
    input  wire logic                PROX_VALID,
    input  wire logic [7:0]          PROX_DATA,
    input  wire logic                LIGHT_VALID,
    input  wire logic [LIGHT_DW-1:0] LIGHT_DATA,
    input  wire logic [LIGHT_DW-1:0] LIGHT_LOW_THR,
    input  wire logic [LIGHT_DW-1:0] LIGHT_HIGH_THR,
    input  wire logic                PROX_INT_ENABLE,
    input  wire logic                LIGHT_INT_ENABLE,
    input  wire logic                PROX_INT_CLR,
    input  wire logic                LIGHT_INT_CLR,
    output logic                     PROX_INT_FLAG,
    output logic                     LIGHT_INT_FLAG,
    output logic                     INT_N,
    input  wire logic                WAIT_START,
    output logic                     WAIT_BUSY,
    output logic                     WAIT_DONE,
    input  wire logic                PULSE_START,
    input  wire logic                PULSE_ABORT,
    output logic                     EMIT_PULSE,
    output logic                     PULSE_BUSY
);

    // ================================================================
    // Configuration registers
    logic [7:0]             wait_setting_r;
    logic [7:0]             prox_low_threshold_r;
    logic [7:0]             prox_high_threshold_r;
    pacfg_pkg::pacfg_persistence_filters_t persistence_filters_r;
    pacfg_pkg::pacfg_gcfg_t general_config_r;
    pacfg_pkg::pacfg_pulse_t prox_pulse_config_r;

    // Register writes, unmapped offsets ignored
    always_ff @(posedge CLK) begin
        if (RST) begin
            wait_setting_r        <= pacfg_pkg::RST_WAIT;
            prox_low_threshold_r  <= pacfg_pkg::RST_PROX_LOW;
            prox_high_threshold_r <= pacfg_pkg::RST_PROX_HIGH;
            persistence_filters_r <= pacfg_pkg::RST_PERSISTENCE_FILTERS;
            general_config_r      <= pacfg_pkg::RST_GCFG;
            prox_pulse_config_r   <= pacfg_pkg::RST_PULSE;
        end else if (REG_WR) begin
            if (REG_ADDR == pacfg_pkg::ADDR_WAIT) begin
                wait_setting_r <= REG_WDATA;
            end else if (REG_ADDR == pacfg_pkg::ADDR_PROX_LOW) begin
                prox_low_threshold_r <= REG_WDATA;
            end else if (REG_ADDR == pacfg_pkg::ADDR_PROX_HIGH) begin
                prox_high_threshold_r <= REG_WDATA;
            end else if (REG_ADDR == pacfg_pkg::ADDR_PERSISTENCE_FILTERS) begin
                persistence_filters_r <= REG_WDATA;
            end else if (REG_ADDR == pacfg_pkg::ADDR_GCFG) begin
                general_config_r <= REG_WDATA; // RQ12 RQ14
            end else if (REG_ADDR == pacfg_pkg::ADDR_PULSE) begin
                prox_pulse_config_r <= REG_WDATA;
            end
        end
    end

    // Read data, captured on the read strobe
    logic [7:0] rd_mux;

    always_comb begin
        if (REG_ADDR == pacfg_pkg::ADDR_WAIT) begin
            rd_mux = wait_setting_r;
        end else if (REG_ADDR == pacfg_pkg::ADDR_PROX_LOW) begin
            rd_mux = prox_low_threshold_r;
        end else if (REG_ADDR == pacfg_pkg::ADDR_PROX_HIGH) begin
            rd_mux = prox_high_threshold_r;
        end else if (REG_ADDR == pacfg_pkg::ADDR_PERSISTENCE_FILTERS) begin
            rd_mux = persistence_filters_r;
        end else if (REG_ADDR == pacfg_pkg::ADDR_GCFG) begin
            rd_mux = general_config_r;
        end else if (REG_ADDR == pacfg_pkg::ADDR_PULSE) begin
            rd_mux = prox_pulse_config_r;
        end else begin
            rd_mux = pacfg_pkg::RDATA_NONE;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            REG_RDATA <= pacfg_pkg::RDATA_NONE;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end
    end

    // ================================================================
    // Persistence filters
    logic prox_hit;
    logic light_hit;

    pacfg_persistence_filters_filter #(
        .DW        (8),
        .LIGHT_MAP (1'b0)
    ) u_prox_filter (
        .clk          (CLK),
        .rst          (RST),
        .sample_valid (PROX_VALID),
        .sample       (PROX_DATA),
        .low_thr      (prox_low_threshold_r),
        .high_thr     (prox_high_threshold_r),
        .persistence_filters_code    (persistence_filters_r.prox_persistence),
        .hit          (prox_hit)
    );

    pacfg_persistence_filters_filter #(
        .DW        (LIGHT_DW),
        .LIGHT_MAP (1'b1)
    ) u_light_filter (
        .clk          (CLK),
        .rst          (RST),
        .sample_valid (LIGHT_VALID),
        .sample       (LIGHT_DATA),
        .low_thr      (LIGHT_LOW_THR),
        .high_thr     (LIGHT_HIGH_THR),
        .persistence_filters_code    (persistence_filters_r.light_persistence),
        .hit          (light_hit)
    );

    // ================================================================
    // Sticky flags, set wins over clear, and interrupt pin
    logic prox_flag_nxt;
    logic light_flag_nxt;

    assign prox_flag_nxt  = prox_hit || (PROX_INT_FLAG && !PROX_INT_CLR); // RQ1 RQ13
    assign light_flag_nxt = light_hit || (LIGHT_INT_FLAG && !LIGHT_INT_CLR);

    always_ff @(posedge CLK) begin
        if (RST) begin
            PROX_INT_FLAG  <= 1'b0;
            LIGHT_INT_FLAG <= 1'b0;
            INT_N          <= 1'b1;
        end else begin
            PROX_INT_FLAG  <= prox_flag_nxt;
            LIGHT_INT_FLAG <= light_flag_nxt;
            INT_N          <= !((prox_flag_nxt && PROX_INT_ENABLE) ||
                                (light_flag_nxt && LIGHT_INT_ENABLE)); // RQ2
        end
    end

    // ================================================================
    // Wait timer
    pacfg_wait_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_wait_timer (
        .clk          (CLK),
        .rst          (RST),
        .start        (WAIT_START),
        .wait_setting (wait_setting_r),
        .long_wait    (general_config_r.long_wait),
        .busy         (WAIT_BUSY),
        .done         (WAIT_DONE)
    );

    // ================================================================
    // Emitter pulse train
    pacfg_pkg::pacfg_pstate_t pstate_r;
    pacfg_pkg::pacfg_pulse_t  pulse_cfg_q;
    logic [10:0]              width_q;
    logic [10:0]              phase_r;
    logic [6:0]               pulse_num_r;
    logic [6:0]               pulse_max;
    logic                     train_start;

    assign pulse_max   = {1'b0, pulse_cfg_q.emitter_pulse_count} + 7'h01; // RQ11
    assign train_start = PULSE_START && (pstate_r == pacfg_pkg::PACFG_IDLE);
    assign PULSE_BUSY  = (pstate_r != pacfg_pkg::PACFG_IDLE);

    // Latch train settings at start
    always_ff @(posedge CLK) begin
        if (RST) begin
            pulse_cfg_q <= pacfg_pkg::RST_PULSE;
            width_q     <= pacfg_pkg::PULSE_BASE_CYCLES;
        end else if (train_start) begin
            pulse_cfg_q <= prox_pulse_config_r;
            width_q     <= pacfg_pkg::PULSE_BASE_CYCLES <<
                           prox_pulse_config_r.emitter_pulse_length; // RQ11
        end
    end

    // High and gap phases of equal width
    always_ff @(posedge CLK) begin
        if (RST || PULSE_ABORT) begin
            pstate_r    <= pacfg_pkg::PACFG_IDLE;
            EMIT_PULSE  <= 1'b0;
            phase_r     <= 11'h001;
            pulse_num_r <= 7'h00;
        end else begin
            case (pstate_r)
                pacfg_pkg::PACFG_IDLE: begin
                    if (PULSE_START) begin
                        pstate_r    <= pacfg_pkg::PACFG_HIGH;
                        EMIT_PULSE  <= 1'b1;
                        phase_r     <= 11'h001;
                        pulse_num_r <= 7'h01;
                    end
                end
                pacfg_pkg::PACFG_HIGH: begin
                    if (phase_r == width_q) begin
                        EMIT_PULSE <= 1'b0;
                        phase_r    <= 11'h001;
                        if (pulse_num_r == pulse_max) begin
                            pstate_r <= pacfg_pkg::PACFG_IDLE; // RQ11
                        end else begin
                            pstate_r <= pacfg_pkg::PACFG_GAP;
                        end
                    end else begin
                        phase_r <= phase_r + 11'h001;
                    end
                end
                pacfg_pkg::PACFG_GAP: begin
                    if (phase_r == width_q) begin
                        pstate_r    <= pacfg_pkg::PACFG_HIGH;
                        EMIT_PULSE  <= 1'b1;
                        phase_r     <= 11'h001;
                        pulse_num_r <= pulse_num_r + 7'h01;
                    end else begin
                        phase_r <= phase_r + 11'h001;
                    end
                end
                default: begin
                    pstate_r   <= pacfg_pkg::PACFG_IDLE;
                    EMIT_PULSE <= 1'b0;
                end
            endcase
        end
    end

    // ================================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Helper counters for pulse checks
    logic        emit_q;
    logic [6:0]  seen_r;
    logic [10:0] hi_len_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            emit_q   <= 1'b0;
            seen_r   <= 7'h00;
            hi_len_r <= 11'h000;
        end else begin
            emit_q   <= EMIT_PULSE;
            hi_len_r <= EMIT_PULSE ? hi_len_r + 11'h001 : 11'h000;
            if (train_start) begin
                seen_r <= 7'h00;
            end else if (EMIT_PULSE && !emit_q) begin
                seen_r <= seen_r + 7'h01;
            end
        end
    end

    sequence s_prox_hit;
        prox_hit;
    endsequence

    sequence s_flag_held;
        PROX_INT_FLAG [*2];
    endsequence

    property p_flag_set;
        s_prox_hit |=> PROX_INT_FLAG;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on hit"); // RQ1

    property p_set_wins;
        s_prox_hit and PROX_INT_CLR |=> PROX_INT_FLAG;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a set"); // RQ13

    property p_flag_sticky;
        PROX_INT_FLAG && !PROX_INT_CLR ##1 !PROX_INT_CLR |-> s_flag_held;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // RQ5

    property p_int_pin;
        s_prox_hit and PROX_INT_ENABLE |=> !INT_N;
    endproperty
    a_int_pin: assert property (p_int_pin) else $error("interrupt pin not asserted"); // RQ2

    property p_pulse_count;
        PULSE_BUSY |-> seen_r <= pulse_max;
    endproperty
    a_pulse_count: assert property (p_pulse_count) else $error("too many pulses"); // RQ11

    property p_pulse_width;
        $fell(EMIT_PULSE) && !$past(PULSE_ABORT) |-> hi_len_r == width_q;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong"); // RQ11

endmodule : pacfg_top

// *** rtl/pacfg_pkg.sv ***
package pacfg_pkg;

    // ================================================================
    // Register offsets
    localparam logic [7:0] ADDR_WAIT      = 8'h83;
    localparam logic [7:0] ADDR_PROX_LOW  = 8'h88;
    localparam logic [7:0] ADDR_PROX_HIGH = 8'h8a;
    localparam logic [7:0] ADDR_PERSISTENCE_FILTERS      = 8'h8c;
    localparam logic [7:0] ADDR_GCFG      = 8'h8d;
    localparam logic [7:0] ADDR_PULSE     = 8'h8e;

    // ================================================================
    // Reset values
    localparam logic [7:0] RST_WAIT      = 8'h00;
    localparam logic [7:0] RST_PROX_LOW  = 8'h00;
    localparam logic [7:0] RST_PROX_HIGH = 8'h00;
    localparam logic [7:0] RST_PERSISTENCE_FILTERS      = 8'h00;
    localparam logic [7:0] RST_GCFG      = 8'h80;
    localparam logic [7:0] RST_PULSE     = 8'h4f;
    localparam logic [7:0] RDATA_NONE    = 8'h00;

    // ================================================================
    // Field layouts
    typedef struct packed {
        logic [3:0] prox_persistence;
        logic [3:0] light_persistence;
    } pacfg_persistence_filters_t;

    typedef struct packed {
        logic [4:0] rsv_hi;
        logic       long_wait;
        logic [1:0] rsv_lo;
    } pacfg_gcfg_t;

    typedef struct packed {
        logic [1:0] emitter_pulse_length;
        logic [5:0] emitter_pulse_count;
    } pacfg_pulse_t;

    // ================================================================
    // Persistence code map
    localparam logic [3:0] PERSISTENCE_FILTERS_DIRECT_MAX = 4'h3;
    localparam logic [5:0] LIGHT_STEP      = 6'h05;
    localparam logic [5:0] LIGHT_STEP_BASE = 6'h03;

    // ================================================================
    // Timing
    localparam int  CLK_MHZ            = 40;
    localparam real WAIT_TICK_MS       = 2.8;
    localparam int  WAIT_TICK_CYCLES   = int'(WAIT_TICK_MS * 1000.0 * CLK_MHZ);
    localparam logic [11:0] LONG_WAIT_FACTOR = 12'h00c;
    localparam int  PULSE_BASE_US      = 4;
    localparam logic [10:0] PULSE_BASE_CYCLES = 11'(PULSE_BASE_US * CLK_MHZ);

    // Emitter sequencer states
    typedef enum logic [1:0] {
        PACFG_IDLE = 2'b00,
        PACFG_HIGH = 2'b01,
        PACFG_GAP  = 2'b10
    } pacfg_pstate_t;

endpackage : pacfg_pkg

// *** rtl/pacfg_persistence_filters_filter.sv ***
`timescale 1ns/1ps
module pacfg_persistence_filters_filter #(
    parameter int DW        = 8,
    parameter bit LIGHT_MAP = 1'b0
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          sample_valid,
    input  wire logic [DW-1:0] sample,
    input  wire logic [DW-1:0] low_thr,
    input  wire logic [DW-1:0] high_thr,
    input  wire logic [3:0]    persistence_filters_code,
    output logic               hit
);
    // ================================================================
    // Required run length and window test
    logic       out_of_range;
    logic [5:0] req;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;

    always_comb begin
        if (!LIGHT_MAP || persistence_filters_code <= pacfg_pkg::PERSISTENCE_FILTERS_DIRECT_MAX) begin
            req = {2'b00, persistence_filters_code};
        end else begin
            req = 6'(({2'b00, persistence_filters_code} - pacfg_pkg::LIGHT_STEP_BASE) * pacfg_pkg::LIGHT_STEP); // RQ4
        end
    end

    assign out_of_range = (sample < low_thr) || (sample > high_thr); // RQ1 RQ13

    // Run counter, cleared inside window
    always_comb begin
        if (!out_of_range) begin
            cnt_nxt = 6'h00; // RQ6 RQ8
        end else if (cnt_r == 6'h3f) begin
            cnt_nxt = cnt_r;
        end else begin
            cnt_nxt = cnt_r + 6'h01; // RQ5 RQ7
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 6'h00;
        end else if (sample_valid) begin
            cnt_r <= cnt_nxt;
        end
    end

    // Hit pulse one cycle after the sample
    always_ff @(posedge clk) begin
        if (rst) begin
            hit <= 1'b0;
        end else begin
            hit <= sample_valid && (persistence_filters_code == 4'h0 || (out_of_range && cnt_nxt == req)); // RQ3 RQ5
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_clear_inside;
        sample_valid && !out_of_range |=> cnt_r == 6'h00;
    endproperty
    a_clear_inside: assert property (p_clear_inside) else $error("run count not cleared"); // RQ6

    property p_any_out;
        sample_valid && out_of_range && persistence_filters_code == 4'h1 && cnt_r == 6'h00 |=> hit;
    endproperty
    a_any_out: assert property (p_any_out) else $error("single excursion missed"); // RQ5

    property p_light_map;
        LIGHT_MAP && persistence_filters_code == 4'h7 |-> req == 6'h14;
    endproperty
    a_light_map: assert property (p_light_map) else $error("light code map wrong"); // RQ4
endmodule : pacfg_persistence_filters_filter

// *** rtl/pacfg_wait_timer.sv ***
`timescale 1ns/1ps
module pacfg_wait_timer #(
    parameter int TICK_CYCLES = pacfg_pkg::WAIT_TICK_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [7:0] wait_setting,
    input  wire logic       long_wait,
    output logic            busy,
    output logic            done
);
    localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    // ================================================================
    // Load value and tick prescaler
    logic [11:0]   base;
    logic [11:0]   load_val;
    logic [11:0]   ticks_r;
    logic [PW-1:0] pre_r;
    logic          tick;

    assign base     = {4'h0, wait_setting} + 12'h001; // RQ9
    assign load_val = long_wait ? 12'(base * pacfg_pkg::LONG_WAIT_FACTOR) : base; // RQ10
    assign tick     = busy && (pre_r == PRE_LAST);

    always_ff @(posedge clk) begin
        if (rst || !busy || tick) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + PW'(1);
        end
    end

    // Down counter of ticks
    always_ff @(posedge clk) begin
        if (rst) begin
            ticks_r <= 12'h000;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                ticks_r <= load_val; // RQ9
                busy    <= 1'b1;
            end else if (tick) begin
                ticks_r <= ticks_r - 12'h001;
                if (ticks_r == 12'h001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_load;
        start && !busy |=> busy && ticks_r == $past(load_val);
    endproperty
    a_load: assert property (p_load) else $error("wait load wrong"); // RQ9

    property p_long;
        start && !busy && long_wait && wait_setting == 8'h00 |=> ticks_r == 12'h00c;
    endproperty
    a_long: assert property (p_long) else $error("long wait factor wrong"); // RQ10
endmodule : pacfg_wait_timer

// *** test/pacfg_host_model.sv ***
`timescale 1ns/1ps
// ================================================================
// Host processor on the register strobes
module pacfg_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr = 8'h00,
    output logic      [7:0] wdata = 8'h00,
    output logic            wr = 1'b0,
    output logic            rd = 1'b0
);
    // Write strobe for one edge, then data inverted
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask : put

    // Read strobe, data registered one edge later
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        #1;
        d = rdata;
    endtask : get

    // Reserved fields always keep their defaults
    task automatic set_long(input logic lw);
        put(8'h8d, {5'b10000, lw, 2'b00});
    endtask : set_long
endmodule : pacfg_host_model

// *** test/tb_prox_als_persistence_config.sv ***
`timescale 1ns/1ps
module tb_prox_als_persistence_config;
    localparam int T = 4;
    logic        clk = 1'b0, rst = 1'b1, pv = 1'b0, lv = 1'b0, pen = 1'b0, len = 1'b0;
    logic        pclr = 1'b0, lclr = 1'b0, ws = 1'b0, ps = 1'b0, pa = 1'b0;
    logic [7:0]  pd = 8'h00, addr, wdata, rdata, v;
    logic [15:0] ld = 16'h0000;
    logic        wr, rd, pflag, lflag, int_n, wbusy, wdone, emit, pbusy;
    int          bad_count = 0;
    int          compares = 0;
    logic [7:0]  ra [6] = '{8'h83, 8'h88, 8'h8a, 8'h8c, 8'h8d, 8'h8e};
    logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h4f};
    logic [7:0]  wv [6] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h84, 8'h81};

    // ================================================================
    // Clock, host and design
    always #12.5 clk = ~clk;

    pacfg_host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    pacfg_top #(.TICK_CYCLES(T)) DUT (
        .CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .PROX_VALID(pv), .PROX_DATA(pd), .LIGHT_VALID(lv), .LIGHT_DATA(ld),
        .LIGHT_LOW_THR(16'h0100), .LIGHT_HIGH_THR(16'h8000), .PROX_INT_ENABLE(pen),
        .LIGHT_INT_ENABLE(len), .PROX_INT_CLR(pclr), .LIGHT_INT_CLR(lclr),
        .PROX_INT_FLAG(pflag), .LIGHT_INT_FLAG(lflag), .INT_N(int_n), .WAIT_START(ws),
        .WAIT_BUSY(wbusy), .WAIT_DONE(wdone), .PULSE_START(ps), .PULSE_ABORT(pa),
        .EMIT_PULSE(emit), .PULSE_BUSY(pbusy)
    );

    // ================================================================
    // Compare, verdict and helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("%0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Consecutive light results needed per persistence code
    function automatic int need(input int c);
        return (c < 4) ? c : 5 * (c - 3);
    endfunction : need

    // One result, flag and pin checked, then flag cleared
    task automatic sample(input logic lt, input logic [15:0] d, input logic exp);
        @(posedge clk);
        pv <= !lt;
        lv <= lt;
        pd <= d[7:0];
        ld <= d;
        @(posedge clk);
        pv <= 1'b0;
        lv <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(lt ? lflag : pflag, exp, "flag");
        check(int_n, !(exp && (lt ? len : pen)), "pin");
        @(posedge clk);
        pclr <= 1'b1;
        lclr <= 1'b1;
        @(posedge clk);
        pclr <= 1'b0;
        lclr <= 1'b0;
    endtask : sample

    // Wait run with a second start while busy
    task automatic wait_run(input logic [7:0] w, input logic lw);
        int n = 0;
        host.put(8'h83, w);
        host.set_long(lw);
        ws <= 1'b1;
        while (n < 3000 && wdone !== 1'b1) begin
            @(posedge clk);
            ws <= (n == 1);
            #1;
            n += (wbusy === 1'b1);
        end
        check(n, (w + 1) * T * (lw ? 12 : 1), "wait");
        @(posedge clk);
        #1;
        check({wdone, wbusy}, 2'b00, "idle");
    endtask : wait_run

    // Pulse train, counting emitter high cycles and rising edges
    task automatic train(input logic [1:0] pl, input logic [5:0] pc, input int stop);
        int   hi = 0;
        int   rises = 0;
        logic was = 1'b0;
        host.put(8'h8e, {pl, pc});
        ps <= 1'b1;
        @(posedge clk);
        ps <= 1'b0;
        for (int n = 1; n < 30000; n++) begin
            #1;
            hi += (emit === 1'b1);
            rises += (emit === 1'b1 && !was);
            was = (emit === 1'b1);
            if (pbusy !== 1'b1) break;
            @(posedge clk);
            pa <= (n == stop);
        end
        @(posedge clk);
        pa <= 1'b0;
        #1;
        if (stop == 0) begin
            check(hi, (160 << pl) * (pc + 1), "high");
            check(rises, pc + 1, "pulses");
        end else begin
            check(hi < (160 << pl), 1'b1, "abort");
        end
        check(emit, 1'b0, "emit off");
        check(pbusy, 1'b0, "busy off");
    endtask : train

    // ================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            host.get(ra[i], v);
            check(v, rv[i], "reset");
            host.put(ra[i], wv[i]);
            host.get(ra[i], v);
            check(v, wv[i], "readback");
        end
        host.put(8'h90, 8'h55);
        host.get(8'h90, v);
        check(v, 8'h00, "unmapped");
        $display("test registers done");
        host.put(8'h88, 8'h20);
        host.put(8'h8a, 8'h80);
        for (int c = 0; c < 16; c++) begin
            host.put(8'h8c, {c[3:0], 4'h0});
            pen <= c[0];
            sample(1'b0, c[0] ? 16'h0080 : 16'h0020, c == 0);
            for (int k = 1; k < c; k++) sample(1'b0, 16'h0081, 1'b0);
            sample(1'b0, c[1] ? 16'h001f : 16'h0081, 1'b1);
            sample(1'b0, 16'h00ff, c == 0);
        end
        // Hit and clear in the same cycle, the set must win
        host.put(8'h8c, 8'h00);
        pv <= 1'b1;
        @(posedge clk);
        pv   <= 1'b0;
        pclr <= 1'b1;
        @(posedge clk);
        pclr <= 1'b0;
        #1;
        check(pflag, 1'b1, "set wins");
        sample(1'b0, 16'h0050, 1'b1);
        $display("test proximity done");
        for (int c = 0; c < 16; c++) begin
            host.put(8'h8c, {4'h0, c[3:0]});
            len <= c[0];
            sample(1'b1, c[0] ? 16'h8000 : 16'h0100, c == 0);
            for (int k = 1; k < need(c); k++) sample(1'b1, 16'h00ff, 1'b0);
            sample(1'b1, c[1] ? 16'h00ff : 16'h8001, 1'b1);
        end
        $display("test light done");
        wait_run(8'h00, 1'b0);
        wait_run(8'h01, 1'b0);
        wait_run(8'h02, 1'b1);
        wait_run(8'h00, 1'b1);
        $display("test wait done");
        train(2'h0, 6'h02, 0);
        train(2'h1, 6'h00, 0);
        train(2'h2, 6'h01, 0);
        train(2'h3, 6'h00, 0);
        train(2'h0, 6'h3f, 0);
        train(2'h1, 6'h05, 10);
        $display("test pulses done");
        give_verdict();
    end

    // Watchdog, about twice the expected run
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule : tb_prox_als_persistence_config
